//--- pog_edge_if.sv
// Carrier between the register core and one per-output edge offset stage.
// Assumes one instance per PWM output, all on the core clock.
`timescale 1ns/1ps
interface pog_edge_if #(parameter int TIME_W = 12, parameter int MOD_W = 8);
    logic [TIME_W-1:0] base_rise;
    logic [TIME_W-1:0] base_fall;
    logic rise_en;
    logic rise_neg;
    logic fall_en;
    logic fall_neg;
    logic signed [MOD_W-1:0] mod;
    logic [TIME_W-1:0] rise_time;
    logic [TIME_W-1:0] fall_time;
    modport ctrl (output base_rise, base_fall, rise_en, rise_neg, fall_en, fall_neg, mod,
        input rise_time, fall_time);
    modport calc (input base_rise, base_fall, rise_en, rise_neg, fall_en, fall_neg, mod,
        output rise_time, fall_time);
endinterface

//--- pog_edge_mod.sv
// Per-output edge offset stage: adds or subtracts the signed balance term on one rising and one falling edge.
// Assumes inputs are stable core-clock signals; result is registered and clamped to the time range.
`timescale 1ns/1ps
module pog_edge_mod
    import pog_pkg::*;
#(
    parameter int TIME_W = pog_pkg::TIME_W,
    parameter int MOD_W = pog_pkg::MOD_W
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Edge settings and result
    pog_edge_if.calc eif
);

    localparam int SUM_W = TIME_W + 2;
    localparam logic signed [SUM_W-1:0] TIME_MAX = SUM_W'((1 << TIME_W) - 1);

    // Clamping avoids a wrap that would throw an edge across the whole period
    function automatic logic [TIME_W-1:0] offset_edge(input logic [TIME_W-1:0] base, input logic en,
        input logic neg, input logic signed [MOD_W-1:0] mod);
        logic signed [SUM_W-1:0] sum;
        logic signed [SUM_W-1:0] term;
        sum = signed'({2'b00, base});
        term = {{(SUM_W - MOD_W){mod[MOD_W-1]}}, mod};
        if (en)
        begin
            sum = neg ? sum - term : sum + term;
        end
        if (sum < 0)
        begin
            sum = '0;
        end
        else if (sum > TIME_MAX)
        begin
            sum = TIME_MAX;
        end
        return sum[TIME_W-1:0];
    endfunction

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            eif.rise_time <= '0;
            eif.fall_time <= '0;
        end
        else
        begin
            eif.rise_time <= offset_edge(eif.base_rise, eif.rise_en, eif.rise_neg, eif.mod);
            eif.fall_time <= offset_edge(eif.base_fall, eif.fall_en, eif.fall_neg, eif.mod);
        end
    end

endmodule

//--- pog_pkg.sv
// Shared constants for the PWM output gate, shadow latch and balance steering block.
// Assumes register indices are 16-bit; the byte address on the bus is four times the index.
package pog_pkg;

    localparam int N_OUT = 8;
    localparam int TIME_W = 12;
    localparam int MOD_W = 8;
    localparam int CS_W = 12;
    localparam int AXI_ADDR_W = 18;
    localparam int IDX_W = 16;

    // Edge time resolution
    localparam int EDGE_LSB_PS = 5000;

    // Register indices
    localparam logic [15:0] IDX_FREQ_FIRST = 16'hFE0A;
    localparam logic [15:0] IDX_FREQ_LAST = 16'hFE0C;
    localparam logic [15:0] IDX_VREF_FIRST = 16'hFE22;
    localparam logic [15:0] IDX_VREF_LAST = 16'hFE25;
    localparam logic [15:0] IDX_EDGE_FIRST = 16'hFE40;
    localparam logic [15:0] IDX_EDGE_LAST = 16'hFE5F;
    localparam logic [15:0] IDX_OUT_DISABLE = 16'hFE60;
    localparam logic [15:0] IDX_GO_CMD = 16'hFE61;
    localparam logic [15:0] IDX_STEER_12 = 16'hFE62;
    localparam logic [15:0] IDX_STEER_34 = 16'hFE63;
    localparam logic [15:0] IDX_STEER_5TO8 = 16'hFE64;
    localparam logic [15:0] IDX_BAL_MODE = 16'hFE70;
    localparam logic [15:0] IDX_BAL_VALUE = 16'hFE71;

    // Command register fields
    localparam int GO_FREQ_BIT = 3;
    localparam int GO_PWM_BIT = 2;
    localparam int GO_VREF_B_BIT = 1;
    localparam int GO_VREF_A_BIT = 0;
    localparam int GO_W = 4;

    // Steering field positions within a two-output byte
    localparam int STEER_HI_RISE_EN = 7;
    localparam int STEER_HI_RISE_DIR = 6;
    localparam int STEER_HI_FALL_EN = 5;
    localparam int STEER_HI_FALL_DIR = 4;
    localparam int STEER_LO_RISE_EN = 3;
    localparam int STEER_LO_RISE_DIR = 2;
    localparam int STEER_LO_FALL_EN = 1;
    localparam int STEER_LO_FALL_DIR = 0;

    // Edge block layout: rise MSBs, fall MSBs, LSB nibbles, settings
    localparam int EDGE_RISE_MSB_OFS = 0;
    localparam int EDGE_FALL_MSB_OFS = 1;
    localparam int EDGE_LSB_OFS = 2;
    localparam int EDGE_SET_OFS = 3;
    localparam int EDGE_STRIDE = 4;

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [GO_W-1:0] RST_GO = 4'h0;
    localparam logic [1:0] RST_BAL_MODE = 2'h0;

    // Balance modes
    typedef enum logic [1:0] {
        POG_BAL_OFF,
        POG_BAL_VOLT_SECOND,
        POG_BAL_CURRENT,
        POG_BAL_RSVD
    } pog_bal_mode_t;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

endpackage

//--- pog_stage_model.sv
// Power stage seen from the gated outputs: one switch per output.
// Assumes outputs change only on aclk.
`timescale 1ns/1ps
module pog_stage_model
(
    // Clock and gate drive
    input wire logic aclk,
    input wire logic [7:0] pwm_bus,
    // Switch state
    output logic [7:0] stage_on_ff
);
    always_ff @(posedge aclk) stage_on_ff <= pwm_bus;
endmodule

//--- pog_tb_top.sv
// Register-level bench for pog_top over AXI4-Lite.
// Assumes checker bound to pog_top and the stage model alongside.
`timescale 1ns/1ps
module pog_tb_top;
    import pog_pkg::*;
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, balance_tick;
    logic pwm_output_1, pwm_output_2, pwm_output_3, pwm_output_4;
    logic pwm_output_5, pwm_output_6, pwm_output_7, pwm_output_8;
    logic [17:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rv;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp, rr;
    logic [7:0] pwm_raw, stage_on_ff, outs;
    logic [11:0] cs_after_pwm_output_1_rise, cs_after_pwm_output_2_rise, phase_a_current_sense_one, phase_a_current_sense_two;
    logic [11:0] phase_b_current_sense_one, phase_b_current_sense_two;
    logic [95:0] rising_edge_time, falling_edge_time;
    logic [63:0] output_settings_shadow;
    logic [23:0] freq_shadow;
    logic [15:0] channel_a_voltage_sense_ref, channel_b_voltage_sense_ref;
    logic signed [7:0] balance_mod;
    int n_mismatch = 0;
    int check_count = 0;
    assign outs = {pwm_output_8, pwm_output_7, pwm_output_6, pwm_output_5,
        pwm_output_4, pwm_output_3, pwm_output_2, pwm_output_1};
    pog_top u_pog_top (.*);
    pog_stage_model u_pog_stage_model (.aclk(aclk), .pwm_bus(outs), .stage_on_ff(stage_on_ff));
    initial
    begin
        aclk = 0;
        forever #25 aclk = ~aclk;
    end
    ////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task wr(input logic [15:0] i, input logic [7:0] d);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'h0};
        s_axi_wdata <= {24'h0, d};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'h7;
        do
        begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 1'h0;
            if (s_axi_wready) s_axi_wvalid <= 1'h0;
        end
        while (!s_axi_bvalid);
        s_axi_bready <= 1'h0;
    endtask
    task rd(input logic [15:0] i);
        @(posedge aclk);
        s_axi_araddr <= {i, 2'h0};
        {s_axi_arvalid, s_axi_rready} <= 2'h3;
        do
        begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 1'h0;
        end
        while (!s_axi_rvalid);
        {rv, rr} = {s_axi_rdata, s_axi_rresp};
        s_axi_rready <= 1'h0;
    endtask
    task tick(input int n);
        repeat (n)
        begin
            @(posedge aclk);
            balance_tick <= 1'h1;
            @(posedge aclk);
            balance_tick <= 1'h0;
        end
        repeat (2) @(posedge aclk);
    endtask
    task report_and_stop;
        $display("Mismatches %0d, checks %0d", n_mismatch, check_count);
        if (n_mismatch == 0 && check_count > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    initial
    begin
        #(20000 * 50);
        n_mismatch++;
        report_and_stop();
    end
    initial
    begin
        aresetn = 0;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready, balance_tick} = 6'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 68'h0;
        s_axi_wstrb = 4'hF;
        pwm_raw = 8'hFF;
        {cs_after_pwm_output_1_rise, cs_after_pwm_output_2_rise, phase_a_current_sense_one, phase_a_current_sense_two,
            phase_b_current_sense_one, phase_b_current_sense_two} = 72'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'h1;
        for (int k = 0; k < 5; k++)
        begin
            rd(IDX_OUT_DISABLE + 16'(k));
            chk(rv, 32'h0);
        end
        wr(IDX_OUT_DISABLE, 8'hA5);
        repeat (3) @(posedge aclk);
        chk(outs, 8'h5A);
        chk(stage_on_ff, 8'h5A);
        rd(16'h0000);
        chk(rr, RESP_SLVERR);
        wr(IDX_FREQ_FIRST, 8'h12);
        wr(IDX_FREQ_FIRST + 16'h1, 8'h34);
        wr(IDX_FREQ_LAST, 8'h56);
        chk(freq_shadow, 24'h0);
        wr(IDX_GO_CMD, 8'h08);
        repeat (2) @(posedge aclk);
        chk(freq_shadow, 24'h563412);
        for (int k = 0; k < 4; k++) wr(IDX_VREF_FIRST + 16'(k), 8'(8'h11 * (k + 1)));
        wr(IDX_GO_CMD, 8'h01);
        repeat (2) @(posedge aclk);
        chk(channel_a_voltage_sense_ref, 16'h3311);
        chk(channel_b_voltage_sense_ref, 16'h0);
        wr(IDX_GO_CMD, 8'h02);
        repeat (2) @(posedge aclk);
        chk(channel_b_voltage_sense_ref, 16'h4422);
        wr(IDX_EDGE_FIRST, 8'hAB);
        wr(IDX_EDGE_FIRST + 16'h1, 8'hCD);
        wr(IDX_EDGE_FIRST + 16'h2, 8'h5E);
        wr(IDX_EDGE_FIRST + 16'h14, 8'h10);
        wr(IDX_EDGE_LAST, 8'h80);
        chk(rising_edge_time[11:0], 12'h0);
        wr(IDX_GO_CMD, 8'h04);
        repeat (2) @(posedge aclk);
        chk(rising_edge_time[11:0], 12'hAB5);
        chk(falling_edge_time[11:0], 12'hCDE);
        chk(output_settings_shadow[63:56], 8'h80);
        wr(IDX_BAL_MODE, 8'h02);
        phase_a_current_sense_one <= 12'h100;
        tick(3);
        chk(balance_mod, 32'h3);
        wr(IDX_BAL_MODE, 8'h01);
        cs_after_pwm_output_1_rise <= 12'h200;
        tick(1);
        chk(balance_mod, 32'h4);
        wr(IDX_STEER_12, 8'h0B);
        wr(IDX_STEER_34, 8'h08);
        wr(IDX_STEER_5TO8, 8'h0A);
        repeat (3) @(posedge aclk);
        chk(rising_edge_time[11:0], 12'hAB9);
        chk(falling_edge_time[11:0], 12'hCDA);
        chk(rising_edge_time[23:12], 12'h0);
        chk(rising_edge_time[35:24], 12'h4);
        chk(rising_edge_time[59:48], 12'h4);
        chk(rising_edge_time[71:60], 12'h0FC);
        report_and_stop();
    end
endmodule

//--- pog_top.sv
// PWM output gating, GO-strobed shadow latches and balance steering, with an AXI4-Lite register port.
// Assumes raw PWM, current-sense values and the balance tick come from logic on aclk.
//
// Notes on behaviour
// - Eight disable bits, one per output.
// - Frequency GO copies frequency staging to shadow.
// - PWM GO copies edge staging to shadow.
// - Channel B GO copies its reference staging.
// - Channel A GO copies its reference staging.
// - Volt-second mode: larger first-half sense increases modulation.
// - Current mode: any larger phase-A sense increases modulation.
// - Outputs 1-2 have rising and falling enables.
// - Direction bit below enable: 1 means earlier.
// - Outputs 3-4 use the same enable layout.
// - Outputs 5-8 have enable bits only.
// - Outputs 5,7 move later; 6,8 earlier.
// - Edge times are 12 bits, 5 ns steps.
`timescale 1ns/1ps
module pog_top
    import pog_pkg::*;
#(
    parameter int N_OUT = pog_pkg::N_OUT,
    parameter int TIME_W = pog_pkg::TIME_W,
    parameter int MOD_W = pog_pkg::MOD_W,
    parameter int CS_W = pog_pkg::CS_W
)
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // AXI4-Lite write channels
    input wire logic [pog_pkg::AXI_ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read channels
    input wire logic [pog_pkg::AXI_ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Raw edge generator outputs
    input wire logic [N_OUT-1:0] pwm_raw,
    // Balance sense inputs
    input wire logic balance_tick,
    input wire logic [CS_W-1:0] cs_after_pwm_output_1_rise,
    input wire logic [CS_W-1:0] cs_after_pwm_output_2_rise,
    input wire logic [CS_W-1:0] phase_a_current_sense_one,
    input wire logic [CS_W-1:0] phase_a_current_sense_two,
    input wire logic [CS_W-1:0] phase_b_current_sense_one,
    input wire logic [CS_W-1:0] phase_b_current_sense_two,
    // Gated PWM pins
    output logic pwm_output_1,
    output logic pwm_output_2,
    output logic pwm_output_3,
    output logic pwm_output_4,
    output logic pwm_output_5,
    output logic pwm_output_6,
    output logic pwm_output_7,
    output logic pwm_output_8,
    // Working shadow values
    output logic [N_OUT*TIME_W-1:0] rising_edge_time,
    output logic [N_OUT*TIME_W-1:0] falling_edge_time,
    output logic [N_OUT*8-1:0] output_settings_shadow,
    output logic [23:0] freq_shadow,
    output logic [15:0] channel_a_voltage_sense_ref,
    output logic [15:0] channel_b_voltage_sense_ref,
    output logic signed [MOD_W-1:0] balance_mod
);

    localparam int N_FREQ = 3;
    localparam int N_VREF = 4;
    localparam int N_EDGE = 32;
    localparam logic signed [MOD_W-1:0] MOD_MAX = {1'b0, {(MOD_W-1){1'b1}}};
    localparam logic signed [MOD_W-1:0] MOD_MIN = {1'b1, {(MOD_W-1){1'b0}}};

    ////////////////////////////////////////////////////////////////////////////
    // Bus handshake

    logic aw_held_ff, w_held_ff, w_lane0_ff;
    logic [IDX_W-1:0] aw_idx_ff, ar_idx;
    logic [7:0] w_byte_ff, rd_byte;
    logic wr_fire, wr_hit, rd_hit, wr_ok;

    assign s_axi_awready = !aw_held_ff;
    assign s_axi_wready = !w_held_ff;
    assign s_axi_arready = !s_axi_rvalid;
    // Commit once both halves are held and the previous response is gone
    assign wr_fire = aw_held_ff && w_held_ff && !s_axi_bvalid;
    assign ar_idx = s_axi_araddr[AXI_ADDR_W-1:2];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_held_ff <= 1'b0;
            aw_idx_ff <= '0;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_held_ff <= 1'b1;
            aw_idx_ff <= s_axi_awaddr[AXI_ADDR_W-1:2];
        end
        else if (wr_fire)
            aw_held_ff <= 1'b0;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_held_ff <= 1'b0;
            w_byte_ff <= RST_BYTE;
            w_lane0_ff <= 1'b0;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_held_ff <= 1'b1;
            w_byte_ff <= s_axi_wdata[7:0];
            w_lane0_ff <= s_axi_wstrb[0];
        end
        else if (wr_fire)
            w_held_ff <= 1'b0;
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= RESP_OKAY;
        end
        else if (wr_fire)
        begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_bready)
            s_axi_bvalid <= 1'b0;
    end
    ////////////////////////////////////////////////////////////////////////////
    // Staging, control and shadow storage

    logic [7:0] freq_stage_ff [N_FREQ], freq_sh_ff [N_FREQ];
    logic [7:0] vref_stage_ff [N_VREF], vref_sh_ff [N_VREF];
    logic [7:0] edge_stage_ff [N_EDGE], edge_sh_ff [N_EDGE];
    logic [7:0] disable_ff, steer12_ff, steer34_ff, steer58_ff;
    logic [GO_W-1:0] go_ff, go_pulse;
    pog_bal_mode_t bal_mode_ff;

    assign wr_ok = wr_fire && w_lane0_ff;
    assign wr_hit = (aw_idx_ff >= IDX_FREQ_FIRST && aw_idx_ff <= IDX_FREQ_LAST)
        || (aw_idx_ff >= IDX_VREF_FIRST && aw_idx_ff <= IDX_VREF_LAST)
        || (aw_idx_ff >= IDX_EDGE_FIRST && aw_idx_ff <= IDX_EDGE_LAST)
        || (aw_idx_ff >= IDX_OUT_DISABLE && aw_idx_ff <= IDX_STEER_5TO8)
        || aw_idx_ff == IDX_BAL_MODE || aw_idx_ff == IDX_BAL_VALUE;
    assign go_pulse = (wr_ok && aw_idx_ff == IDX_GO_CMD) ? w_byte_ff[GO_W-1:0] : RST_GO;

    // Staging only; nothing downstream reads these directly
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            freq_stage_ff <= '{default: RST_BYTE};
            vref_stage_ff <= '{default: RST_BYTE};
            edge_stage_ff <= '{default: RST_BYTE};
        end
        else if (wr_ok)
        begin
            if (aw_idx_ff >= IDX_FREQ_FIRST && aw_idx_ff <= IDX_FREQ_LAST)
                freq_stage_ff[2'(aw_idx_ff - IDX_FREQ_FIRST)] <= w_byte_ff;
            else if (aw_idx_ff >= IDX_VREF_FIRST && aw_idx_ff <= IDX_VREF_LAST)
                vref_stage_ff[2'(aw_idx_ff - IDX_VREF_FIRST)] <= w_byte_ff;
            else if (aw_idx_ff >= IDX_EDGE_FIRST && aw_idx_ff <= IDX_EDGE_LAST)
                edge_stage_ff[5'(aw_idx_ff - IDX_EDGE_FIRST)] <= w_byte_ff;
        end
    end
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            disable_ff <= RST_BYTE;
            go_ff <= RST_GO;
            steer12_ff <= RST_BYTE;
            steer34_ff <= RST_BYTE;
            steer58_ff <= RST_BYTE;
            bal_mode_ff <= pog_bal_mode_t'(RST_BAL_MODE);
        end
        else if (wr_ok)
        begin
            if (aw_idx_ff == IDX_OUT_DISABLE)
                disable_ff <= w_byte_ff;
            else if (aw_idx_ff == IDX_GO_CMD)
                go_ff <= w_byte_ff[GO_W-1:0];
            else if (aw_idx_ff == IDX_STEER_12)
                steer12_ff <= w_byte_ff;
            else if (aw_idx_ff == IDX_STEER_34)
                steer34_ff <= w_byte_ff;
            else if (aw_idx_ff == IDX_STEER_5TO8)
                steer58_ff <= w_byte_ff;
            else if (aw_idx_ff == IDX_BAL_MODE)
                bal_mode_ff <= pog_bal_mode_t'(w_byte_ff[1:0]);
        end
    end

    // Each group moves only on its own command bit
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            freq_sh_ff <= '{default: RST_BYTE};
            vref_sh_ff <= '{default: RST_BYTE};
            edge_sh_ff <= '{default: RST_BYTE};
        end
        else
        begin
            if (go_pulse[GO_FREQ_BIT])
                freq_sh_ff <= freq_stage_ff;
            if (go_pulse[GO_PWM_BIT])
                edge_sh_ff <= edge_stage_ff;
            if (go_pulse[GO_VREF_B_BIT])
                {vref_sh_ff[1], vref_sh_ff[3]} <= {vref_stage_ff[1], vref_stage_ff[3]};
            if (go_pulse[GO_VREF_A_BIT])
                {vref_sh_ff[0], vref_sh_ff[2]} <= {vref_stage_ff[0], vref_stage_ff[2]};
        end
    end
    assign freq_shadow = {freq_sh_ff[2], freq_sh_ff[1], freq_sh_ff[0]};
    assign channel_a_voltage_sense_ref = {vref_sh_ff[2], vref_sh_ff[0]};
    assign channel_b_voltage_sense_ref = {vref_sh_ff[3], vref_sh_ff[1]};

    ////////////////////////////////////////////////////////////////////////////
    // Balance modulation integrator

    logic mod_up, mod_down;

    assign mod_up = (bal_mode_ff == POG_BAL_VOLT_SECOND && cs_after_pwm_output_1_rise > cs_after_pwm_output_2_rise)
        || (bal_mode_ff == POG_BAL_CURRENT && (phase_a_current_sense_one > phase_b_current_sense_one
        || phase_a_current_sense_two > phase_b_current_sense_two));
    assign mod_down = (bal_mode_ff == POG_BAL_VOLT_SECOND && cs_after_pwm_output_1_rise < cs_after_pwm_output_2_rise)
        || (bal_mode_ff == POG_BAL_CURRENT && (phase_a_current_sense_one < phase_b_current_sense_one
        || phase_a_current_sense_two < phase_b_current_sense_two));

    // Saturating so a long imbalance cannot wrap the sign
    always_ff @(posedge aclk)
    begin
        if (!aresetn || bal_mode_ff == POG_BAL_OFF || bal_mode_ff == POG_BAL_RSVD)
            balance_mod <= '0;
        else if (balance_tick && mod_up && balance_mod != MOD_MAX)
            balance_mod <= balance_mod + MOD_W'(1);
        else if (balance_tick && !mod_up && mod_down && balance_mod != MOD_MIN)
            balance_mod <= balance_mod - MOD_W'(1);
    end

    ////////////////////////////////////////////////////////////////////////////
    // Per-output edge steering

    logic [2*N_OUT-1:0] edge_en;
    logic [2*N_OUT-1:0] edge_neg;

    // Pairs {rise, fall} per output; outputs 5 to 8 have fixed signs
    assign edge_en[3:0] = {steer12_ff[STEER_LO_RISE_EN], steer12_ff[STEER_LO_FALL_EN],
        steer12_ff[STEER_HI_RISE_EN], steer12_ff[STEER_HI_FALL_EN]};
    assign edge_neg[3:0] = {steer12_ff[STEER_LO_RISE_DIR], steer12_ff[STEER_LO_FALL_DIR],
        steer12_ff[STEER_HI_RISE_DIR], steer12_ff[STEER_HI_FALL_DIR]};
    assign edge_en[7:4] = {steer34_ff[STEER_LO_RISE_EN], steer34_ff[STEER_LO_FALL_EN],
        steer34_ff[STEER_HI_RISE_EN], steer34_ff[STEER_HI_FALL_EN]};
    assign edge_neg[7:4] = {steer34_ff[STEER_LO_RISE_DIR], steer34_ff[STEER_LO_FALL_DIR],
        steer34_ff[STEER_HI_RISE_DIR], steer34_ff[STEER_HI_FALL_DIR]};
    assign edge_en[15:8] = steer58_ff;
    assign edge_neg[15:8] = 8'hCC;

    pog_edge_if #(.TIME_W(TIME_W), .MOD_W(MOD_W)) eif [N_OUT] ();

    genvar g;
    generate
        for (g = 0; g < N_OUT; g++)
        begin : g_out
            localparam int B = g * EDGE_STRIDE;
            // Slot order in edge_en: pwm_output_1 at [3:2], pwm_output_2 at [1:0], pwm_output_3 [7:6], pwm_output_4 [5:4]...
            localparam int S = (g < 4) ? ((g % 2 == 0) ? 2 * g + 2 : 2 * g - 2) : 2 * g;
            assign eif[g].base_rise = {edge_sh_ff[B + EDGE_RISE_MSB_OFS], edge_sh_ff[B + EDGE_LSB_OFS][7:4]};
            assign eif[g].base_fall = {edge_sh_ff[B + EDGE_FALL_MSB_OFS], edge_sh_ff[B + EDGE_LSB_OFS][3:0]};
            assign eif[g].rise_en = edge_en[S + 1];
            assign eif[g].rise_neg = edge_neg[S + 1];
            assign eif[g].fall_en = edge_en[S];
            assign eif[g].fall_neg = edge_neg[S];
            assign eif[g].mod = balance_mod;
            assign rising_edge_time[g*TIME_W +: TIME_W] = eif[g].rise_time;
            assign falling_edge_time[g*TIME_W +: TIME_W] = eif[g].fall_time;
            assign output_settings_shadow[g*8 +: 8] = edge_sh_ff[B + EDGE_SET_OFS];
            pog_edge_mod #(.TIME_W(TIME_W), .MOD_W(MOD_W)) u_edge (
                .aclk(aclk),
                .aresetn(aresetn),
                .eif(eif[g])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Output gating

    logic [N_OUT-1:0] pwm_gated_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            pwm_gated_ff <= '0;
        else
            pwm_gated_ff <= pwm_raw & ~disable_ff[N_OUT-1:0];
    end
    assign {pwm_output_8, pwm_output_7, pwm_output_6, pwm_output_5,
        pwm_output_4, pwm_output_3, pwm_output_2, pwm_output_1} = pwm_gated_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Read path

    always_comb
    begin
        rd_hit = 1'b1;
        rd_byte = RST_BYTE;
        if (ar_idx >= IDX_FREQ_FIRST && ar_idx <= IDX_FREQ_LAST)
            rd_byte = freq_stage_ff[2'(ar_idx - IDX_FREQ_FIRST)];
        else if (ar_idx >= IDX_VREF_FIRST && ar_idx <= IDX_VREF_LAST)
            rd_byte = vref_stage_ff[2'(ar_idx - IDX_VREF_FIRST)];
        else if (ar_idx >= IDX_EDGE_FIRST && ar_idx <= IDX_EDGE_LAST)
            rd_byte = edge_stage_ff[5'(ar_idx - IDX_EDGE_FIRST)];
        else if (ar_idx == IDX_OUT_DISABLE)
            rd_byte = disable_ff;
        else if (ar_idx == IDX_GO_CMD)
            rd_byte = {4'h0, go_ff};
        else if (ar_idx == IDX_STEER_12)
            rd_byte = steer12_ff;
        else if (ar_idx == IDX_STEER_34)
            rd_byte = steer34_ff;
        else if (ar_idx == IDX_STEER_5TO8)
            rd_byte = steer58_ff;
        else if (ar_idx == IDX_BAL_MODE)
            rd_byte = {6'h00, bal_mode_ff};
        else if (ar_idx == IDX_BAL_VALUE)
            rd_byte = 8'(balance_mod);
        else
            rd_hit = 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= RESP_OKAY;
        end
        else if (s_axi_arvalid && s_axi_arready)
        begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= {24'h00_0000, rd_byte};
            s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end
        else if (s_axi_rready)
            s_axi_rvalid <= 1'b0;
    end

endmodule

//--- pog_top_assertions.sv
// Port checker for pog_top.
// Assumes one clock, aclk, and synchronous active-low aresetn.
`timescale 1ns/1ps
module pog_chk
    import pog_pkg::*;
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Outputs and shadows
    input wire logic [7:0] pwm_raw,
    input wire logic pwm_output_1,
    input wire logic balance_tick,
    input wire logic signed [7:0] balance_mod,
    input wire logic [23:0] freq_shadow,
    input wire logic [15:0] channel_a_voltage_sense_ref,
    input wire logic [15:0] channel_b_voltage_sense_ref
);
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence wr_taken;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && !s_axi_bvalid;
    endsequence
    write_resp_a: assert property (wr_taken |-> ##2 s_axi_bvalid) else $error("write not answered");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    read_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read not answered");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    rdata_upper_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0) else $error("upper read bits set");
    ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid) else $error("arready wrong");
    out_gate_a: assert property (pwm_output_1 |-> $past(pwm_raw[0])) else $error("output high without raw");
    bal_step_a: assert property ($changed(balance_mod) && balance_mod != 8'sh0 |-> $past(balance_tick))
        else $error("modulation moved without tick");
    // Shadows move only as a result of a committed write
    shadow_go_a: assert property ($changed({freq_shadow, channel_a_voltage_sense_ref, channel_b_voltage_sense_ref})
        |-> s_axi_bvalid) else $error("shadow moved without write");
endmodule

bind pog_top pog_chk u_pog_chk (.*);
